/* File: hdl/oas_pkg.sv */
// constants, register map and state type of the output acquisition sequencer
package oas_pkg;
  localparam int unsigned OAS_CLK_NS = 20;
  localparam int unsigned OAS_TICK_NS = 20480;
  localparam int unsigned OAS_TICK_CYC = (OAS_TICK_NS + OAS_CLK_NS - 1) / OAS_CLK_NS;
  localparam int unsigned OAS_TICK_W = $clog2(OAS_TICK_CYC);

  localparam logic [7:0] OAS_CMD = 8'h00;
  localparam logic [7:0] OAS_STATUS = 8'h04;
  localparam logic [7:0] OAS_FUNC = 8'h08;
  localparam logic [7:0] OAS_POINTS = 8'h0C;
  localparam logic [7:0] OAS_PERIOD = 8'h10;
  localparam logic [7:0] OAS_OFFSET = 8'h14;
  localparam logic [7:0] OAS_VRANGE = 8'h18;
  localparam logic [7:0] OAS_IRANGE = 8'h1C;
  localparam logic [7:0] OAS_VRES = 8'h20;
  localparam logic [7:0] OAS_IRES = 8'h24;
  localparam logic [7:0] OAS_AIDX = 8'h28;
  localparam logic [7:0] OAS_ADATA = 8'h2C;
  localparam int unsigned OAS_KW_BIT = 6;

  localparam int unsigned OAS_CMD_MEAS = 0;
  localparam int unsigned OAS_CMD_FETCH = 1;
  localparam int unsigned OAS_CMD_ARM = 2;
  localparam int unsigned OAS_CMD_QTY = 3;
  localparam int unsigned OAS_FN_CURR = 0;
  localparam int unsigned OAS_FN_HANN = 1;
  localparam int unsigned OAS_AIDX_SEL = 16;

  localparam int unsigned OAS_ST_BUSY = 0;
  localparam int unsigned OAS_ST_DONE = 1;
  localparam int unsigned OAS_ST_ERR = 2;
  localparam int unsigned OAS_ST_BUFV = 3;
  localparam int unsigned OAS_ST_QTY = 4;
  localparam int unsigned OAS_ST_BOTH = 5;
  localparam int unsigned OAS_ST_WAIT = 6;
  localparam int unsigned OAS_ST_VOKV = 7;
  localparam int unsigned OAS_ST_VOKI = 8;

  localparam int unsigned OAS_PTS_MAX = 4096;
  localparam logic [12:0] OAS_PTS_RST = 13'h0400;
  // sample period is written in half-tick units of 10.24 us
  localparam logic [31:0] OAS_PER_MIN = 32'h00000002;
  localparam logic [31:0] OAS_PER_MAX = 32'hE8D4A510;
  localparam logic [30:0] OAS_PER_RST = 31'h00000001;
  localparam logic [31:0] OAS_OFF_MIN = 32'hFFFFF001;
  localparam logic [31:0] OAS_OFF_MAX = 32'h77359400;

  typedef enum logic [2:0] {OAS_IDLE, OAS_PRE, OAS_WAIT, OAS_DELAY, OAS_CAPT, OAS_AVG, OAS_DIV} oas_state_t;
endpackage : oas_pkg

/* File: hdl/oas_acq_seq.sv */
// measurement acquisition sequencer: sampling, capture buffer, windowed averaging, APB registers
//
// The implementer's own choices: the placing of the registers and register access over APB.
module oas_acq_seq import oas_pkg::*; #(
  parameter int unsigned PTS_MAX = OAS_PTS_MAX,
  parameter bit SIMULT = 1'b0,
  parameter int unsigned NRANGE = 2,
  parameter logic [NRANGE*32-1:0] V_RANGES = {32'h0000C350, 32'h00001388},
  parameter logic [NRANGE*32-1:0] I_RANGES = {32'h000F4240, 32'h000186A0}
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic acq_trig,
  input wire logic signed [15:0] adc_volt,
  input wire logic signed [15:0] adc_curr,
  output logic conv_strobe,
  output logic [1:0] vrange_sel,
  output logic [1:0] irange_sel,
  output logic acq_busy
);
  typedef struct packed {
    oas_state_t st;
    logic [OAS_TICK_W-1:0] tick;
    logic [30:0] per_cnt;
    logic [30:0] per_ticks;
    logic [12:0] points;
    logic [31:0] offset;
    logic func;
    logic hann;
    logic [1:0] vrng;
    logic [1:0] irng;
    logic [11:0] wp;
    logic [11:0] start;
    logic [12:0] pre;
    logic [12:0] idx;
    logic [11:0] aidx;
    logic asel;
    logic [31:0] remain;
    logic auto_trig;
    logic acq_qty;
    logic both;
    logic buf_valid;
    logic ok_v;
    logic ok_i;
    logic done;
    logic err;
    logic div_i;
    logic [47:0] accv;
    logic [47:0] acci;
    logic [31:0] sumw;
    logic [47:0] dvd;
    logic [31:0] rem;
    logic [5:0] dbit;
    logic dneg;
    logic [15:0] vres;
    logic [15:0] ires;
    logic [31:0] prdata;
  } oas_regs_t;

  oas_regs_t st_reg;
  oas_regs_t st_next;
  logic signed [15:0] mem_v [PTS_MAX];
  logic signed [15:0] mem_i [PTS_MAX];
  logic mem_we;
  logic mem_we_v;
  logic mem_we_i;

  logic setup;
  logic wr;
  logic kw;
  logic [7:0] base;
  logic idle;
  logic sampling;
  logic strobe;
  logic [12:0] span;
  logic [25:0] wprod;
  logic [31:0] wsq;
  logic [16:0] weight;
  logic [12:0] rsum;
  logic [11:0] ridx;
  logic [12:0] asum;
  logic [11:0] aix;
  logic signed [15:0] rv;
  logic signed [15:0] ri;
  logic signed [33:0] pv;
  logic signed [33:0] pi;
  logic bus_err;

  function automatic logic [1:0] pick(input logic [31:0] v, input logic [NRANGE*32-1:0] tbl);
    logic [1:0] sel;
    sel = 2'(NRANGE - 1);
    for (int i = NRANGE - 1; i >= 0; i--) begin
      if (v <= tbl[i*32 +: 32]) sel = 2'(i);
    end
    return sel;
  endfunction : pick

  function automatic logic [11:0] wrap(input logic [12:0] v, input logic [12:0] n);
    return (v >= n) ? 12'(v - n) : v[11:0];
  endfunction : wrap

  assign setup = psel && !penable && ce;
  assign wr = psel && penable && pwrite && ce;
  assign kw = paddr[OAS_KW_BIT];
  assign base = paddr & ~(8'h01 << OAS_KW_BIT);
  assign idle = (st_reg.st == OAS_IDLE);
  assign sampling = (st_reg.st == OAS_PRE) || (st_reg.st == OAS_WAIT) ||
                    (st_reg.st == OAS_DELAY) || (st_reg.st == OAS_CAPT);
  // one sample per per_ticks base ticks, half the programmed half-tick period rounded up
  assign strobe = sampling && (st_reg.tick == OAS_TICK_W'(OAS_TICK_CYC - 1)) &&
                  (st_reg.per_cnt == st_reg.per_ticks - 31'h1);
  assign conv_strobe = strobe;
  // half-sine approximated by a parabola, then squared once for the raised-cosine weight
  assign span = st_reg.points - st_reg.idx;
  assign wprod = st_reg.idx * span;
  assign wsq = wprod[22:7] * wprod[22:7];
  assign weight = st_reg.hann ? ({1'b0, wsq[31:16]} + 17'h00001) : 17'h00001;
  assign rsum = {1'b0, st_reg.start} + st_reg.idx;
  assign ridx = wrap(rsum, st_reg.points);
  assign asum = {1'b0, st_reg.start} + {1'b0, st_reg.aidx};
  assign aix = wrap(asum, st_reg.points);
  assign rv = mem_v[ridx];
  assign ri = mem_i[ridx];
  assign pv = rv * $signed({1'b0, weight});
  assign pi = ri * $signed({1'b0, weight});
  assign mem_we_v = mem_we && (st_reg.both || !st_reg.acq_qty);
  assign mem_we_i = mem_we && (st_reg.both || st_reg.acq_qty);

  always_comb begin
    logic [31:0] wval;
    logic [31:0] lo;
    logic [31:0] hi;
    logic [31:0] offmag;
    logic [11:0] wpn;
    logic [32:0] trial;
    logic [47:0] qnew;
    logic [47:0] av;
    logic [47:0] ai;
    logic [31:0] sw;
    logic q;
    wval = pwdata;
    lo = 32'h00000000;
    hi = 32'hFFFFFFFF;
    offmag = 32'h00000000;
    wpn = st_reg.wp;
    trial = 33'h000000000;
    qnew = 48'h000000000000;
    av = st_reg.accv;
    ai = st_reg.acci;
    sw = st_reg.sumw;
    q = pwdata[OAS_CMD_QTY];
    st_next = st_reg;
    mem_we = 1'b0;
    bus_err = 1'b0;

    case (base)
      OAS_POINTS: begin
        lo = 32'h00000001;
        hi = 32'(PTS_MAX);
      end
      OAS_PERIOD: begin
        lo = OAS_PER_MIN;
        hi = OAS_PER_MAX;
      end
      OAS_OFFSET: begin
        lo = OAS_OFF_MIN;
        hi = OAS_OFF_MAX;
      end
      OAS_VRANGE: begin
        lo = V_RANGES[31:0];
        hi = V_RANGES[(NRANGE-1)*32 +: 32];
      end
      OAS_IRANGE: begin
        lo = I_RANGES[31:0];
        hi = I_RANGES[(NRANGE-1)*32 +: 32];
      end
      default: begin
        lo = 32'h00000000;
        hi = 32'hFFFFFFFF;
      end
    endcase
    if (kw) wval = pwdata[0] ? hi : lo;

    if (wr) begin
      if (kw && !(base == OAS_POINTS || base == OAS_PERIOD || base == OAS_OFFSET ||
                  base == OAS_VRANGE || base == OAS_IRANGE)) begin
        bus_err = 1'b1;
      end else begin
        case (base)
          OAS_CMD: begin
            if (!idle) begin
              bus_err = 1'b1;
            end else if (pwdata[OAS_CMD_MEAS] || pwdata[OAS_CMD_ARM]) begin
              offmag = 32'h00000000 - st_reg.offset;
              st_next.acq_qty = pwdata[OAS_CMD_MEAS] ? q : st_reg.func;
              st_next.both = SIMULT;
              st_next.auto_trig = pwdata[OAS_CMD_MEAS];
              st_next.done = 1'b0;
              st_next.buf_valid = 1'b0;
              st_next.ok_v = 1'b0;
              st_next.ok_i = 1'b0;
              st_next.wp = 12'h000;
              st_next.tick = '0;
              st_next.per_cnt = 31'h0;
              st_next.pre = 13'h0000;
              // averaging must restart at the first point, or a run after a fetch starts mid-buffer
              st_next.idx = 13'h0000;
              st_next.accv = 48'h000000000000;
              st_next.acci = 48'h000000000000;
              st_next.sumw = 32'h00000000;
              if (st_reg.offset[31]) begin
                st_next.pre = (offmag > {19'h0, st_reg.points}) ? st_reg.points : offmag[12:0];
              end
              st_next.remain = {19'h0, st_next.pre};
              st_next.st = (st_next.pre != 13'h0000) ? OAS_PRE : OAS_WAIT;
            end else if (pwdata[OAS_CMD_FETCH]) begin
              if (!st_reg.buf_valid || (!st_reg.both && st_reg.acq_qty != q)) begin
                bus_err = 1'b1;
              end else begin
                st_next.done = 1'b0;
                st_next.idx = 13'h0000;
                st_next.accv = 48'h000000000000;
                st_next.acci = 48'h000000000000;
                st_next.sumw = 32'h00000000;
                st_next.st = OAS_AVG;
              end
            end
          end
          OAS_STATUS: begin
            if (pwdata[OAS_ST_ERR]) st_next.err = 1'b0;
          end
          OAS_FUNC: begin
            if (!idle) begin
              bus_err = 1'b1;
            end else begin
              st_next.func = pwdata[OAS_FN_CURR];
              st_next.hann = pwdata[OAS_FN_HANN];
            end
          end
          OAS_POINTS: begin
            if (!idle || wval < lo || wval > hi) bus_err = 1'b1;
            else st_next.points = wval[12:0];
          end
          OAS_PERIOD: begin
            if (!idle || wval < lo || wval > hi) bus_err = 1'b1;
            else st_next.per_ticks = 31'((33'(wval) + 33'h1) >> 1);
          end
          OAS_OFFSET: begin
            if (!idle || $signed(wval) < $signed(lo) || $signed(wval) > $signed(hi)) bus_err = 1'b1;
            else st_next.offset = wval;
          end
          OAS_VRANGE: begin
            if (wval > hi) bus_err = 1'b1;
            else st_next.vrng = pick(wval, V_RANGES);
          end
          OAS_IRANGE: begin
            if (wval > hi) bus_err = 1'b1;
            else st_next.irng = pick(wval, I_RANGES);
          end
          OAS_AIDX: begin
            st_next.aidx = pwdata[11:0];
            st_next.asel = pwdata[OAS_AIDX_SEL];
          end
          default: bus_err = 1'b1;
        endcase
      end
    end else if (psel && penable && ce && !(base == OAS_CMD || base == OAS_STATUS || base == OAS_FUNC ||
                 base == OAS_POINTS || base == OAS_PERIOD || base == OAS_OFFSET || base == OAS_VRANGE ||
                 base == OAS_IRANGE || base == OAS_VRES || base == OAS_IRES || base == OAS_AIDX ||
                 base == OAS_ADATA) || (psel && penable && ce && !pwrite && kw)) begin
      bus_err = 1'b1;
    end
    if (bus_err) st_next.err = 1'b1;

    // read data is captured in the setup cycle so the access phase needs no wait state
    if (setup) begin
      case (paddr)
        OAS_STATUS: st_next.prdata = {23'h0, st_reg.ok_i, st_reg.ok_v, (st_reg.st == OAS_WAIT), st_reg.both,
                                      st_reg.acq_qty, st_reg.buf_valid, st_reg.err, st_reg.done, !idle};
        OAS_FUNC: st_next.prdata = {30'h0, st_reg.hann, st_reg.func};
        OAS_POINTS: st_next.prdata = {19'h0, st_reg.points};
        OAS_PERIOD: st_next.prdata = {st_reg.per_ticks, 1'b0};
        OAS_OFFSET: st_next.prdata = st_reg.offset;
        OAS_VRANGE: st_next.prdata = V_RANGES[st_reg.vrng*32 +: 32];
        OAS_IRANGE: st_next.prdata = I_RANGES[st_reg.irng*32 +: 32];
        OAS_VRES: st_next.prdata = {16'h0, st_reg.vres};
        OAS_IRES: st_next.prdata = {16'h0, st_reg.ires};
        OAS_AIDX: st_next.prdata = {15'h0, st_reg.asel, 4'h0, st_reg.aidx};
        OAS_ADATA: st_next.prdata = {16'h0, st_reg.asel ? mem_i[aix] : mem_v[aix]};
        default: st_next.prdata = 32'h00000000;
      endcase
    end

    if (sampling) begin
      st_next.tick = (st_reg.tick == OAS_TICK_W'(OAS_TICK_CYC - 1)) ? '0 : st_reg.tick + 1'b1;
      if (st_reg.tick == OAS_TICK_W'(OAS_TICK_CYC - 1)) begin
        st_next.per_cnt = (st_reg.per_cnt == st_reg.per_ticks - 31'h1) ? 31'h0 : st_reg.per_cnt + 31'h1;
      end
      if (strobe && st_reg.st != OAS_DELAY) begin
        mem_we = 1'b1;
        wpn = wrap({1'b0, st_reg.wp} + 13'h0001, st_reg.points);
        st_next.wp = wpn;
      end
    end

    case (st_reg.st)
      OAS_IDLE: begin
      end
      OAS_PRE: begin
        if (strobe) begin
          st_next.remain = st_reg.remain - 32'h1;
          if (st_reg.remain == 32'h1) st_next.st = OAS_WAIT;
        end
      end
      OAS_WAIT: begin
        if (st_reg.auto_trig || acq_trig) begin
          st_next.start = wrap({1'b0, wpn} + st_reg.points - st_reg.pre, st_reg.points);
          if (!st_reg.offset[31] && st_reg.offset != 32'h0) begin
            st_next.remain = st_reg.offset;
            st_next.st = OAS_DELAY;
          end else begin
            st_next.remain = {19'h0, st_reg.points - st_reg.pre};
            st_next.st = (st_reg.points == st_reg.pre) ? OAS_AVG : OAS_CAPT;
          end
        end
      end
      OAS_DELAY: begin
        if (strobe) begin
          st_next.remain = st_reg.remain - 32'h1;
          if (st_reg.remain == 32'h1) begin
            st_next.start = st_reg.wp;
            st_next.remain = {19'h0, st_reg.points};
            st_next.st = OAS_CAPT;
          end
        end
      end
      OAS_CAPT: begin
        if (strobe) begin
          st_next.remain = st_reg.remain - 32'h1;
          if (st_reg.remain == 32'h1) st_next.st = OAS_AVG;
        end
      end
      OAS_AVG: begin
        av = st_reg.accv + 48'($signed(pv));
        ai = st_reg.acci + 48'($signed(pi));
        sw = st_reg.sumw + 32'(weight);
        st_next.accv = av;
        st_next.acci = ai;
        st_next.sumw = sw;
        st_next.idx = st_reg.idx + 13'h0001;
        if (st_reg.idx == st_reg.points - 13'h0001) begin
          st_next.dvd = av[47] ? 48'h0 - av : av;
          st_next.dneg = av[47];
          st_next.rem = 32'h0;
          st_next.dbit = 6'd47;
          st_next.div_i = 1'b0;
          st_next.st = OAS_DIV;
        end
      end
      OAS_DIV: begin
        trial = {st_reg.rem, st_reg.dvd[47]};
        qnew = {st_reg.dvd[46:0], trial >= {1'b0, st_reg.sumw}};
        st_next.rem = (trial >= {1'b0, st_reg.sumw}) ? 32'(trial - {1'b0, st_reg.sumw}) : trial[31:0];
        st_next.dvd = qnew;
        st_next.dbit = st_reg.dbit - 6'd1;
        if (st_reg.dbit == 6'd0) begin
          qnew = st_reg.dneg ? 48'h0 - qnew : qnew;
          st_next.rem = 32'h0;
          st_next.dbit = 6'd47;
          if (!st_reg.div_i) begin
            st_next.vres = qnew[15:0];
            st_next.div_i = 1'b1;
            st_next.dvd = st_reg.acci[47] ? 48'h0 - st_reg.acci : st_reg.acci;
            st_next.dneg = st_reg.acci[47];
          end else begin
            st_next.ires = qnew[15:0];
            st_next.buf_valid = 1'b1;
            st_next.ok_v = st_reg.both || !st_reg.acq_qty;
            st_next.ok_i = st_reg.both || st_reg.acq_qty;
            st_next.done = 1'b1;
            st_next.st = OAS_IDLE;
          end
        end
      end
      default: st_next.st = OAS_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.st <= OAS_IDLE;
      st_reg.per_ticks <= OAS_PER_RST;
      st_reg.points <= OAS_PTS_RST;
      st_reg.vrng <= 2'(NRANGE - 1);
      st_reg.irng <= 2'(NRANGE - 1);
      st_reg.dbit <= 6'd47;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // only the acquisition path writes the buffer, so fetch and readout never disturb it
  always_ff @(posedge pclk) begin
    if (ce && mem_we_v) mem_v[st_reg.wp] <= adc_volt;
    if (ce && mem_we_i) mem_i[st_reg.wp] <= adc_curr;
  end

  assign prdata = st_reg.prdata;
  assign pready = ce;
  assign pslverr = bus_err;
  assign vrange_sel = st_reg.vrng;
  assign irange_sel = st_reg.irng;
  assign acq_busy = !idle;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_meas_start: assert property (wr && base == OAS_CMD && !kw && pwdata[OAS_CMD_MEAS] && idle |=> !idle)
    else $error("measure did not start acquisition");
  chk_done_from_div: assert property ($rose(st_reg.done) |-> $past(st_reg.st) == OAS_DIV && st_reg.buf_valid)
    else $error("done without completed averaging");
  chk_fetch_no_write: assert property (mem_we |-> st_reg.st inside {OAS_PRE, OAS_WAIT, OAS_CAPT})
    else $error("buffer written outside acquisition");
  chk_fetch_mismatch: assert property (wr && base == OAS_CMD && !kw && idle && !pwdata[OAS_CMD_MEAS] &&
    !pwdata[OAS_CMD_ARM] && pwdata[OAS_CMD_FETCH] && !st_reg.both && st_reg.acq_qty != pwdata[OAS_CMD_QTY]
    |=> st_reg.err && idle)
    else $error("mismatched fetch not refused");
  chk_simult_both: assert property (wr && base == OAS_CMD && !kw && idle && pwdata[OAS_CMD_MEAS]
    |=> st_reg.both == SIMULT)
    else $error("simultaneous capture flag wrong");
  chk_points_limit: assert property (st_reg.points >= 13'h0001 && st_reg.points <= 13'(PTS_MAX))
    else $error("point count out of limits");
  chk_offset_limit: assert property ($signed(st_reg.offset) >= $signed(OAS_OFF_MIN) &&
    $signed(st_reg.offset) <= $signed(OAS_OFF_MAX))
    else $error("offset out of limits");
  chk_range_cover: assert property (wr && base == OAS_VRANGE && !kw && pwdata <= V_RANGES[(NRANGE-1)*32 +: 32]
    |=> V_RANGES[st_reg.vrng*32 +: 32] >= $past(pwdata))
    else $error("selected range does not cover value");
  chk_range_query: assert property (setup && paddr == OAS_VRANGE |=> prdata == V_RANGES[st_reg.vrng*32 +: 32])
    else $error("range readback wrong");
  chk_period_round: assert property (wr && base == OAS_PERIOD && !kw && idle && pwdata >= OAS_PER_MIN &&
    pwdata <= OAS_PER_MAX |=> st_reg.per_ticks == 31'((33'($past(pwdata)) + 33'h1) >> 1))
    else $error("period not rounded to tick");
  chk_delay_idle: assert property (st_reg.st == OAS_DELAY |-> !mem_we)
    else $error("sample stored during post-trigger delay");

  cov_measure_done: cover property (st_reg.auto_trig && $rose(st_reg.done));
  cov_fetch: cover property (idle && wr && base == OAS_CMD && pwdata[OAS_CMD_FETCH] ##1 st_reg.st == OAS_AVG);
  cov_ext_trig: cover property (st_reg.st == OAS_WAIT && acq_trig && !st_reg.auto_trig);
  cov_hann_done: cover property (st_reg.hann && $rose(st_reg.done));
endmodule : oas_acq_seq

/* File: verification/oas_adc_model.sv */
// converter stand-in: square-wave ripple around levels set by the bench
module oas_adc_model (
  input wire logic pclk,
  input wire logic conv_strobe,
  input wire logic signed [15:0] v_lvl,
  input wire logic signed [15:0] i_lvl,
  output logic signed [15:0] adc_volt,
  output logic signed [15:0] adc_curr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ph = 1'b0;
  // ripple flips per sample, so any even count of equally weighted samples averages to the level
  always @(posedge pclk) if (conv_strobe) ph <= ~ph;
  assign adc_volt = ph ? v_lvl + 16'sh0008 : v_lvl - 16'sh0008;
  assign adc_curr = ph ? i_lvl + 16'sh0008 : i_lvl - 16'sh0008;
endmodule : oas_adc_model

/* File: verification/output_acquisition_sequencer_tb.sv */
// testbench of the acquisition sequencer: APB tasks, limits, measure, fetch, arm
module output_acquisition_sequencer_tb;
  import oas_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, acq_trig = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, conv_strobe, acq_busy, er;
  logic [1:0] vrange_sel, irange_sel;
  logic signed [15:0] adc_volt, adc_curr, v_lvl = 16'sh0123, i_lvl = 16'shFFC0;
  int n_fail = 0, num_checks = 0, n_strobe = 0, s0;
  always #10 pclk = ~pclk;
  always @(posedge pclk) if (conv_strobe) n_strobe <= n_strobe + 1;
  oas_acq_seq dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .acq_trig, .adc_volt, .adc_curr, .conv_strobe, .vrange_sel, .irange_sel, .acq_busy);
  oas_adc_model adc (.pclk, .conv_strobe, .v_lvl, .i_lvl, .adc_volt, .adc_curr);
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  task ck(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : ck
  task xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 100) begin
        n_fail++;
        complete_run();
      end
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xf
  task wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    xf(1'b1, a, d);
    ck($sformatf("pslverr at %h", a), {31'h0, e}, {31'h0, er});
  endtask : wr
  task rc(input logic [7:0] a, input logic [31:0] e);
    xf(1'b0, a, 32'h0);
    ck($sformatf("read %h", a), e, rd);
  endtask : rc
  task rl(input logic [7:0] a, input logic [15:0] e);
    xf(1'b0, a, 32'h0);
    ck($sformatf("result %h", a), {16'h0, e}, {16'h0, rd[15:0]});
  endtask : rl
  // each poll is a setup, an access and one idle cycle, so each try costs three cycles
  task wd;
    int n;
    n = 0;
    do begin
      xf(1'b0, OAS_STATUS, 32'h0);
      n++;
    end while (rd[OAS_ST_DONE] !== 1'b1 && n < 4000);
    if (rd[OAS_ST_DONE] !== 1'b1) begin
      n_fail++;
      complete_run();
    end
  endtask : wd
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rc(OAS_POINTS, 32'h400);
    rc(OAS_PERIOD, 32'h2);
    rc(OAS_OFFSET, 32'h0);
    rc(OAS_FUNC, 32'h0);
    rc(OAS_VRANGE, 32'hC350);
    rc(OAS_IRANGE, 32'hF4240);
    ck("irange_sel", 32'h1, {30'h0, irange_sel});
    $display("test reset values done");
    wr(OAS_POINTS, 32'h0, 1'b1);
    wr(OAS_POINTS, 32'h1001, 1'b1);
    wr(8'h4C, 32'h1, 1'b0);
    rc(OAS_POINTS, 32'h1000);
    wr(8'h58, 32'h0, 1'b0);
    rc(OAS_VRANGE, 32'h1388);
    ck("vrange_sel", 32'h0, {30'h0, vrange_sel});
    wr(OAS_VRANGE, 32'h1389, 1'b0);
    rc(OAS_VRANGE, 32'hC350);
    wr(OAS_VRANGE, 32'hC351, 1'b1);
    wr(OAS_OFFSET, 32'hFFFFF000, 1'b1);
    wr(OAS_OFFSET, 32'hFFFFF001, 1'b0);
    rc(OAS_OFFSET, 32'hFFFFF001);
    wr(OAS_OFFSET, 32'h77359401, 1'b1);
    wr(OAS_PERIOD, 32'h3, 1'b0);
    rc(OAS_PERIOD, 32'h4);
    wr(OAS_PERIOD, 32'h1, 1'b1);
    wr(OAS_PERIOD, 32'h2, 1'b0);
    wr(OAS_CMD, 32'h2, 1'b1);
    $display("test limits done");
    wr(OAS_POINTS, 32'h4, 1'b0);
    wr(OAS_OFFSET, 32'h0, 1'b0);
    s0 = n_strobe;
    wr(OAS_CMD, 32'h1, 1'b0);
    xf(1'b0, OAS_STATUS, 32'h0);
    ck("busy", 32'h1, {31'h0, rd[OAS_ST_BUSY]});
    ck("acq_busy", 32'h1, {31'h0, acq_busy});
    wd();
    ck("acq_busy idle", 32'h0, {31'h0, acq_busy});
    ck("strobes", 32'h4, 32'(n_strobe - s0));
    rl(OAS_VRES, 16'h0123);
    wr(OAS_CMD, 32'hA, 1'b1);
    v_lvl <= 16'sh0200;
    s0 = n_strobe;
    wr(OAS_CMD, 32'h2, 1'b0);
    wd();
    rl(OAS_VRES, 16'h0123);
    ck("fetch strobes", 32'h0, 32'(n_strobe - s0));
    $display("test measure and fetch done");
    wr(OAS_FUNC, 32'h2, 1'b0);
    wr(OAS_CMD, 32'h1, 1'b0);
    wd();
    rl(OAS_VRES, 16'h0200);
    for (int i = 0; i < 4; i++) begin
      wr(OAS_AIDX, 32'(i), 1'b0);
      xf(1'b0, OAS_ADATA, 32'h0);
      ck("raw sample", 32'h1, {31'h0, rd[15:0] == 16'h0208 || rd[15:0] == 16'h01F8});
    end
    $display("test array done");
    wr(OAS_FUNC, 32'h1, 1'b0);
    wr(OAS_OFFSET, 32'h2, 1'b0);
    s0 = n_strobe;
    wr(OAS_CMD, 32'h4, 1'b0);
    xf(1'b0, OAS_STATUS, 32'h0);
    ck("waiting", 32'h1, {31'h0, rd[OAS_ST_WAIT]});
    ck("early strobes", 32'h0, 32'(n_strobe - s0));
    acq_trig <= 1'b1;
    @(posedge pclk);
    acq_trig <= 1'b0;
    wd();
    ck("delayed strobes", 32'h6, 32'(n_strobe - s0));
    rl(OAS_IRES, 16'hFFC0);
    $display("test arm and trigger done");
    // two points before the trigger, two after: four samples in all
    wr(OAS_OFFSET, 32'hFFFFFFFE, 1'b0);
    s0 = n_strobe;
    wr(OAS_CMD, 32'h9, 1'b0);
    wd();
    ck("pre strobes", 32'h4, 32'(n_strobe - s0));
    rl(OAS_IRES, 16'hFFC0);
    $display("test pre-trigger done");
    complete_run();
  end
endmodule : output_acquisition_sequencer_tb
